// file: src/clockgen_host.sv
// Host controller that walks the clock generator through its mode changes
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module clockgen_host
	import clockgen_host_pkg::*;
#(
	parameter int POLL_CYCLES = clockgen_host_pkg::LOCK_WAIT_CYCLES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Software port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// Device register port
	output logic [7:0] devAddr,
	output logic [7:0] devWdata,
	output logic devWr,
	output logic devRd,
	input wire logic [7:0] devRdata
);
	import clockgen_host_pkg::*;

	typedef enum logic [4:0] {
		IDLE = 5'b00001, WRITE = 5'b00010, READ = 5'b00100, RWAIT = 5'b01000, CHECK = 5'b10000
	} state_e;
	typedef enum logic [7:0] {
		ST_INIT = 8'h01, ST_TRIM = 8'h02, ST_FINE = 8'h04, ST_C2 = 8'h08,
		ST_OSC = 8'h10, ST_C1 = 8'h20, ST_C3 = 8'h40, ST_FIN = 8'h80
	} step_e;

	function automatic logic isExt(mode_e m);
		return !(m inside {FLL_ENGAGED_INTERNAL, FLL_BYPASSED_INTERNAL, LOWPOWER_BYPASS_INTERNAL});
	endfunction
	function automatic logic isPll(mode_e m);
		return m inside {PLL_ENGAGED_EXTERNAL, PLL_BYPASSED_EXTERNAL};
	endfunction
	function automatic logic [1:0] clkOf(mode_e m);
		if (m inside {FLL_ENGAGED_INTERNAL, FLL_ENGAGED_EXTERNAL, PLL_ENGAGED_EXTERNAL}) begin
			return SYSCLK_LOOP;
		end
		if (m inside {FLL_BYPASSED_INTERNAL, LOWPOWER_BYPASS_INTERNAL}) begin
			return SYSCLK_INT;
		end
		return SYSCLK_EXT;
	endfunction
	// Low-power bypass keeps no loop running, so no lock is expected there
	function automatic logic needLock(mode_e m);
		return !(m inside {FLL_BYPASSED_INTERNAL, LOWPOWER_BYPASS_INTERNAL, LOWPOWER_BYPASS_EXTERNAL});
	endfunction
	function automatic logic legal(mode_e c, mode_e t);
		unique case (c)
			FLL_ENGAGED_INTERNAL: return t inside {FLL_ENGAGED_EXTERNAL, FLL_BYPASSED_EXTERNAL,
				FLL_BYPASSED_INTERNAL};
			FLL_ENGAGED_EXTERNAL: return t inside {FLL_ENGAGED_INTERNAL, FLL_BYPASSED_EXTERNAL};
			FLL_BYPASSED_EXTERNAL: return t inside {FLL_ENGAGED_EXTERNAL, FLL_BYPASSED_INTERNAL,
				PLL_BYPASSED_EXTERNAL, LOWPOWER_BYPASS_EXTERNAL};
			FLL_BYPASSED_INTERNAL: return t inside {FLL_ENGAGED_INTERNAL, FLL_BYPASSED_EXTERNAL,
				LOWPOWER_BYPASS_INTERNAL};
			PLL_ENGAGED_EXTERNAL: return t == PLL_BYPASSED_EXTERNAL;
			PLL_BYPASSED_EXTERNAL: return t inside {PLL_ENGAGED_EXTERNAL, FLL_BYPASSED_EXTERNAL,
				LOWPOWER_BYPASS_EXTERNAL};
			LOWPOWER_BYPASS_INTERNAL: return t == FLL_BYPASSED_INTERNAL;
			LOWPOWER_BYPASS_EXTERNAL: return t inside {FLL_BYPASSED_EXTERNAL, PLL_BYPASSED_EXTERNAL};
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Host registers
	logic [CFG_WIDTH-1:0] cfg, next_cfg;
	logic [8:0] trimReg, next_trimReg;
	logic [23:0] extFreq, next_extFreq;
	logic [31:0] next_rdata;
	state_e state, next_state;
	step_e step, next_step;
	mode_e curMode, next_curMode, tgtMode, next_tgtMode;
	logic err, next_err, ready, next_ready, trimmed, next_trimmed, c2Done, next_c2Done;
	logic [1:0] errCode, next_errCode;
	logic [7:0] lastSc, next_lastSc;
	logic [7:0] next_devAddr, next_devWdata;
	logic next_devWr, next_devRd;
	logic busy, expired, ffValidExp, rangeOk, scOk;
	logic [1:0] cfgOutDiv;
	logic [2:0] cfgRefDiv;
	logic [24:0] divRef;
	mode_e cmdMode;

	assign busy = (state != IDLE);
	assign cfgOutDiv = cfg[CFG_OUT_DIV_LSB +: 2];
	assign cfgRefDiv = cfg[CFG_REF_DIV_LSB +: 3];
	assign cmdMode = mode_e'(wdata[CMD_MODE_LSB +: 3]);
	assign divRef = {1'b0, extFreq} >> cfgRefDiv;

	// Range check on the requested mode before any device write
	always_comb begin
		rangeOk = 1'b1;
		if (isPll(cmdMode)) begin
			rangeOk = divRef >= PLL_REF_MIN_HZ && divRef <= PLL_REF_MAX_HZ
				&& {1'b0, extFreq} >= PLL_REF_MIN_HZ;
		end else if (isExt(cmdMode) && needLock(cmdMode)) begin
			rangeOk = divRef >= FLL_REF_MIN_HZ && {divRef[23:0], 1'b0} <= FLL_REF_MAX_X2_HZ;
		end
	end

	// Expected validity of the fixed-frequency reference in the mode now held
	always_comb begin
		ffValidExp = 1'b1;
		if (clkOf(curMode) != SYSCLK_LOOP) begin
			if ((cfgOutDiv == OUT_DIV_BY1 && cfgRefDiv < FFV_MIN_DIV_BY1)
				|| (cfgOutDiv == OUT_DIV_BY2 && cfgRefDiv < FFV_MIN_DIV_BY2)) begin
				ffValidExp = 1'b0;
			end
		end
	end

	// Status checks only trust the clock status once the device has switched
	assign scOk = devRdata[SC_INT_REF_STAT] == !isExt(tgtMode)
		&& devRdata[SC_SYSCLK_STAT_LSB +: 2] == clkOf(tgtMode)
		&& devRdata[SC_LOOP_TYPE_STAT] == isPll(tgtMode)
		&& (devRdata[SC_LOCK] || !needLock(tgtMode));

	poll_timer #(.LIMIT(POLL_CYCLES), .W(24)) timer (
		.clk(clk),
		.rstn(rstn),
		.clear(state == WRITE || state == IDLE),
		.expired(expired)
	);

	always_comb begin
		next_cfg = cfg;
		next_trimReg = trimReg;
		next_extFreq = extFreq;
		next_rdata = 32'h0000_0000;
		// Configuration is frozen while a sequence runs
		if (wr && !busy) begin
			unique case (addr)
				HREG_CFG: next_cfg = wdata[CFG_WIDTH-1:0];
				HREG_TRIM: next_trimReg = wdata[8:0];
				HREG_EXTFREQ: next_extFreq = wdata[23:0];
				default: ;
			endcase
		end
		if (rd) begin
			unique case (addr)
				HREG_CMD: next_rdata = {29'h0000_0000, tgtMode};
				HREG_CFG: next_rdata = {18'h0_0000, cfg};
				HREG_TRIM: next_rdata = {23'h00_0000, trimReg};
				HREG_EXTFREQ: next_rdata = {8'h00, extFreq};
				HREG_STATUS: next_rdata = {14'h0000, trimmed, ffValidExp, lastSc, ready, curMode,
					errCode, err, busy};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			cfg <= RST_CFG;
			trimReg <= 9'h000;
			extFreq <= 24'h00_0000;
			rdata <= 32'h0000_0000;
		end else begin
			cfg <= next_cfg;
			trimReg <= next_trimReg;
			extFreq <= next_extFreq;
			rdata <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		next_state = state;
		next_step = step;
		next_curMode = curMode;
		next_tgtMode = tgtMode;
		next_err = err;
		next_errCode = errCode;
		next_ready = ready;
		next_trimmed = trimmed;
		next_c2Done = c2Done;
		next_lastSc = lastSc;
		next_devAddr = devAddr;
		next_devWdata = devWdata;
		next_devWr = 1'b0;
		next_devRd = 1'b0;
		unique case (state)
			IDLE: begin
				next_c2Done = 1'b0;
				if (wr && addr == HREG_CMD && ready && wdata[CMD_TRIM]) begin
					next_err = 1'b0;
					next_state = WRITE;
					next_step = ST_TRIM;
				end else if (wr && addr == HREG_CMD && ready && wdata[CMD_GO]) begin
					next_err = 1'b1;
					if (!legal(curMode, cmdMode)) begin
						next_errCode = ERR_ILLEGAL;
					end else if (!rangeOk || (cfgOutDiv == OUT_DIV_BY1 && !trimmed)) begin
						next_errCode = ERR_REFUSED;
					end else begin
						next_err = 1'b0;
						next_tgtMode = cmdMode;
						next_state = WRITE;
						next_step = ST_C2;
					end
				end
			end
			WRITE: begin
				next_devWr = 1'b1;
				unique case (step)
					ST_TRIM: begin
						next_devAddr = ADDR_TRIM;
						next_devWdata = trimReg[7:0];
						next_step = ST_FINE;
					end
					ST_FINE: begin
						next_devAddr = ADDR_STATUS;
						next_devWdata = {7'h00, trimReg[8]};
						next_trimmed = 1'b1;
						next_state = IDLE;
					end
					ST_C2: begin
						next_devAddr = ADDR_CTRL_TWO;
						next_devWdata = {cfgOutDiv, cfg[CFG_RANGE], cfg[CFG_HIGH_GAIN],
							tgtMode inside {LOWPOWER_BYPASS_INTERNAL, LOWPOWER_BYPASS_EXTERNAL},
							cfg[CFG_EXT_REF_SEL], cfg[CFG_EXT_REF_CLK_EN], 1'b0};
						next_c2Done = 1'b1;
						next_step = ST_C1;
						if (isExt(tgtMode) && cfg[CFG_EXT_REF_SEL]) begin
							next_step = ST_OSC;
							next_state = READ;
						end
					end
					ST_C1: begin
						next_devAddr = ADDR_CTRL_ONE;
						next_devWdata = {clkOf(tgtMode), cfgRefDiv, !isExt(tgtMode),
							cfg[CFG_INT_REF_CLK_EN], 1'b0};
						next_step = ST_C3;
					end
					default: begin
						// Loop type goes last so the new loop sees a settled reference
						next_devAddr = ADDR_CTRL_THREE;
						next_devWdata = {1'b0, isPll(tgtMode), 2'b00,
							cfg[CFG_PLL_MULT_LSB +: 4]};
						next_step = ST_FIN;
						next_state = READ;
					end
				endcase
			end
			READ: begin
				next_devRd = 1'b1;
				next_devAddr = ADDR_STATUS;
				next_state = RWAIT;
			end
			RWAIT: next_state = CHECK;
			CHECK: begin
				next_lastSc = devRdata;
				next_state = READ;
				if (step == ST_INIT && devRdata[SC_LOCK]) begin
					next_ready = 1'b1;
					next_state = IDLE;
				end else if (step == ST_OSC && devRdata[SC_OSC_READY]) begin
					next_step = ST_C1;
					next_state = WRITE;
				end else if (step == ST_FIN && scOk) begin
					next_curMode = tgtMode;
					next_state = IDLE;
				end else if (expired) begin
					next_err = 1'b1;
					next_errCode = ERR_TIMEOUT;
					next_ready = 1'b1;
					next_state = IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= READ;
			step <= ST_INIT;
			curMode <= FLL_ENGAGED_INTERNAL;
			tgtMode <= FLL_ENGAGED_INTERNAL;
			err <= 1'b0;
			errCode <= 2'h0;
			ready <= 1'b0;
			trimmed <= 1'b0;
			c2Done <= 1'b0;
			lastSc <= 8'h00;
			devAddr <= 8'h00;
			devWdata <= 8'h00;
			devWr <= 1'b0;
			devRd <= 1'b0;
		end else begin
			state <= next_state;
			step <= next_step;
			curMode <= next_curMode;
			tgtMode <= next_tgtMode;
			err <= next_err;
			errCode <= next_errCode;
			ready <= next_ready;
			trimmed <= next_trimmed;
			c2Done <= next_c2Done;
			lastSc <= next_lastSc;
			devAddr <= next_devAddr;
			devWdata <= next_devWdata;
			devWr <= next_devWr;
			devRd <= next_devRd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence trimWr_s;
		devWr && devAddr == ADDR_TRIM;
	endsequence
	sequence fineWr_s;
		devWr && devAddr == ADDR_STATUS;
	endsequence
	sequence c1Wr_s;
		devWr && devAddr == ADDR_CTRL_ONE;
	endsequence

	trim_pair_a: assert property (trimWr_s |=> fineWr_s)
		else $error("trim value not followed by fine trim write");
	div_trim_a: assert property (devWr && devAddr == ADDR_CTRL_TWO
		&& devWdata[C2_OUT_DIV_LSB +: 2] == OUT_DIV_BY1 |-> trimmed)
		else $error("divide-by-1 written before trim");
	reset_legal_a: assert property (c1Wr_s and curMode == FLL_ENGAGED_INTERNAL
		|-> tgtMode inside {FLL_ENGAGED_EXTERNAL, FLL_BYPASSED_EXTERNAL, FLL_BYPASSED_INTERNAL})
		else $error("illegal first mode after reset");
	source_first_a: assert property (c1Wr_s |-> c2Done)
		else $error("mode select written before source setup");
	fbe_select_a: assert property (c1Wr_s and tgtMode == FLL_BYPASSED_EXTERNAL
		|-> devWdata[C1_SYSCLK_SEL_LSB +: 2] == SYSCLK_EXT && !devWdata[C1_INT_REF_SEL])
		else $error("bypassed external select wrong");
	osc_wait_a: assert property (c1Wr_s and isExt(tgtMode) && cfg[CFG_EXT_REF_SEL]
		|-> lastSc[SC_OSC_READY])
		else $error("mode select before oscillator ready");
	done_status_a: assert property ($fell(busy) && !err && $past(step) == ST_FIN
		|-> lastSc[SC_SYSCLK_STAT_LSB +: 2] == clkOf(curMode)
		&& lastSc[SC_LOOP_TYPE_STAT] == isPll(curMode)
		&& lastSc[SC_INT_REF_STAT] == !isExt(curMode))
		else $error("sequence ended without matching status");
	fbi_select_a: assert property (c1Wr_s and tgtMode == FLL_BYPASSED_INTERNAL
		|-> devWdata[C1_SYSCLK_SEL_LSB +: 2] == SYSCLK_INT)
		else $error("bypassed internal select wrong");
	loop_last_a: assert property (devWr && devAddr == ADDR_CTRL_THREE |-> $past(devWr)
		&& $past(devAddr) == ADDR_CTRL_ONE)
		else $error("loop type written before divider and internal select");
	ref_range_a: assert property (c1Wr_s and isPll(tgtMode)
		|-> ({1'b0, extFreq} >> devWdata[C1_REF_DIV_LSB +: 3]) >= PLL_REF_MIN_HZ)
		else $error("PLL reference below range");
endmodule // clockgen_host

// file: common/clockgen_host_pkg.sv
// Constants and types for the clock generator host controller
package clockgen_host_pkg;
	typedef enum logic [2:0] {
		FLL_ENGAGED_INTERNAL = 3'h0,
		FLL_ENGAGED_EXTERNAL = 3'h1,
		FLL_BYPASSED_EXTERNAL = 3'h2,
		FLL_BYPASSED_INTERNAL = 3'h3,
		PLL_ENGAGED_EXTERNAL = 3'h4,
		PLL_BYPASSED_EXTERNAL = 3'h5,
		LOWPOWER_BYPASS_INTERNAL = 3'h6,
		LOWPOWER_BYPASS_EXTERNAL = 3'h7
	} mode_e;
	// Device register map
	localparam logic [7:0] ADDR_CTRL_ONE = 8'h48;
	localparam logic [7:0] ADDR_CTRL_TWO = 8'h49;
	localparam logic [7:0] ADDR_TRIM = 8'h4A;
	localparam logic [7:0] ADDR_STATUS = 8'h4B;
	localparam logic [7:0] ADDR_CTRL_THREE = 8'h4C;
	localparam int C1_SYSCLK_SEL_LSB = 6;
	localparam int C1_REF_DIV_LSB = 3;
	localparam int C1_INT_REF_SEL = 2;
	localparam int C1_INT_REF_CLK_EN = 1;
	localparam int C2_OUT_DIV_LSB = 6;
	localparam int C2_RANGE = 5;
	localparam int C2_HIGH_GAIN = 4;
	localparam int C2_LOW_POWER = 3;
	localparam int C2_EXT_REF_SEL = 2;
	localparam int C2_EXT_REF_CLK_EN = 1;
	localparam int C3_LOOP_TYPE_SEL = 6;
	localparam int SC_LOCK = 6;
	localparam int SC_LOOP_TYPE_STAT = 5;
	localparam int SC_INT_REF_STAT = 4;
	localparam int SC_SYSCLK_STAT_LSB = 2;
	localparam int SC_OSC_READY = 1;
	localparam int SC_FINE_TRIM = 0;
	localparam logic [1:0] SYSCLK_LOOP = 2'h0;
	localparam logic [1:0] SYSCLK_INT = 2'h1;
	localparam logic [1:0] SYSCLK_EXT = 2'h2;
	localparam logic [1:0] OUT_DIV_BY1 = 2'h0;
	localparam logic [1:0] OUT_DIV_BY2 = 2'h1;
	localparam logic [1:0] RST_OUT_DIV = OUT_DIV_BY2;
	localparam logic [2:0] RST_REF_DIV = 3'h0;
	localparam logic [2:0] FFV_MIN_DIV_BY1 = 3'h2;
	localparam logic [2:0] FFV_MIN_DIV_BY2 = 3'h3;
	// Reference frequency windows in Hz; FLL upper bound kept doubled to stay integer
	localparam logic [24:0] FLL_REF_MIN_HZ = 25'h000_7A12;
	localparam logic [24:0] FLL_REF_MAX_X2_HZ = 25'h001_312D;
	localparam logic [24:0] PLL_REF_MIN_HZ = 25'h00F_4240;
	localparam logic [24:0] PLL_REF_MAX_HZ = 25'h01E_8480;
	// Host register map
	localparam logic [7:0] HREG_CMD = 8'h00;
	localparam logic [7:0] HREG_CFG = 8'h04;
	localparam logic [7:0] HREG_TRIM = 8'h08;
	localparam logic [7:0] HREG_EXTFREQ = 8'h0C;
	localparam logic [7:0] HREG_STATUS = 8'h10;
	localparam int CMD_MODE_LSB = 0;
	localparam int CMD_GO = 3;
	localparam int CMD_TRIM = 4;
	localparam int CFG_WIDTH = 14;
	localparam int CFG_OUT_DIV_LSB = 0;
	localparam int CFG_REF_DIV_LSB = 2;
	localparam int CFG_PLL_MULT_LSB = 5;
	localparam int CFG_RANGE = 9;
	localparam int CFG_HIGH_GAIN = 10;
	localparam int CFG_EXT_REF_SEL = 11;
	localparam int CFG_EXT_REF_CLK_EN = 12;
	localparam int CFG_INT_REF_CLK_EN = 13;
	localparam logic [CFG_WIDTH-1:0] RST_CFG = 14'h0001;
	localparam logic [1:0] ERR_ILLEGAL = 2'h1;
	localparam logic [1:0] ERR_REFUSED = 2'h2;
	localparam logic [1:0] ERR_TIMEOUT = 2'h3;
	// Poll timeout
	localparam int CLK_FREQ_MHZ = 20;
	localparam int LOCK_WAIT_US = 2000;
	localparam int LOCK_WAIT_CYCLES = LOCK_WAIT_US * CLK_FREQ_MHZ;
endpackage

// file: src/poll_timer.sv
// Poll timeout counter for the clock generator host
`timescale 1ns/1ps
module poll_timer #(
	parameter int LIMIT = 40000,
	parameter int W = 24
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Control
	input wire logic clear,
	output logic expired
);
	logic [W-1:0] count;
	logic [W-1:0] next_count;

	assign expired = (count == W'(LIMIT));

	always_comb begin
		next_count = count;
		if (clear) begin
			next_count = '0;
		end else if (!expired) begin
			next_count = count + W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			count <= '0;
		end else begin
			count <= next_count;
		end
	end
endmodule // poll_timer

// file: test/clockgen_dev_model.sv
// Behavioural model of the clock generator register block
`timescale 1ns/1ps
module clockgen_dev_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] devAddr,
	input wire logic [7:0] devWdata,
	input wire logic devWr,
	input wire logic devRd,
	output logic [7:0] devRdata,
	// Misbehaviour controls
	input wire logic slow,
	input wire logic lockOff
);
	import clockgen_host_pkg::*;
	logic [7:0] c1, c2, trm, c3, cnt, lastRd, rdAddr, rdVal;
	logic fine, stIref, stPll, oscRdy, rdPend, lock;
	logic [1:0] stClk;
	logic [7:0] outDiv, busDiv;
	// Main output is the chosen source over the output divider; bus runs at half of it
	assign outDiv = 8'h01 << c2[C2_OUT_DIV_LSB +: 2];
	assign busDiv = {outDiv[6:0], 1'b0};
	////////////////////////////////////////////////////////////////////////
	// Lock waits for the settle count; lockOff holds it clear for timeouts
	assign lock = !lockOff && (cnt >= (slow ? 8'h14 : 8'h0C));
	always_ff @(posedge clk) begin
		if (!rstn) begin
			c1 <= 8'h04;
			c2 <= 8'h40;
			trm <= 8'h80;
			c3 <= 8'h00;
			cnt <= 8'h00;
			fine <= 1'b0;
			stIref <= 1'b1;
			stClk <= 2'h0;
			stPll <= 1'b0;
			oscRdy <= 1'b0;
			rdPend <= 1'b0;
			rdAddr <= 8'h00;
			lastRd <= 8'h00;
		end else begin
			rdPend <= devRd;
			if (devRd) rdAddr <= devAddr;
			if (cnt != 8'hFF) cnt <= cnt + 8'h01;
			if (devWr) begin
				case (devAddr)
					ADDR_CTRL_ONE: c1 <= devWdata;
					ADDR_CTRL_TWO: c2 <= devWdata;
					ADDR_TRIM: trm <= devWdata;
					ADDR_STATUS: fine <= devWdata[SC_FINE_TRIM];
					ADDR_CTRL_THREE: c3 <= devWdata;
					default: ;
				endcase
				if (devAddr != ADDR_TRIM && devAddr != ADDR_STATUS) cnt <= 8'h00;
			end
			// Status follows the selects only once the switchover has settled
			if (cnt >= 8'h04) begin
				stClk <= c1[7:6];
				stIref <= c1[C1_INT_REF_SEL];
				stPll <= c3[C3_LOOP_TYPE_SEL];
			end
			oscRdy <= c2[C2_EXT_REF_SEL] && (oscRdy || cnt >= 8'h06);
			if (rdPend) lastRd <= devRdata;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Released bus shows the inverse of the last byte, never a stale copy
	always_comb begin
		case (rdAddr)
			ADDR_CTRL_ONE: rdVal = c1;
			ADDR_CTRL_TWO: rdVal = c2;
			ADDR_TRIM: rdVal = trm;
			ADDR_STATUS: rdVal = {1'b0, lock, stPll, stIref, stClk, oscRdy, fine};
			ADDR_CTRL_THREE: rdVal = c3;
			default: rdVal = 8'h00;
		endcase
		devRdata = rdPend ? rdVal : ~lastRd;
	end
endmodule // clockgen_dev_model

// file: test/multi_mode_clock_generator_test.sv
// Self-checking bench for the clock generator host controller
`timescale 1ns/1ps
module multi_mode_clock_generator_test;
	import clockgen_host_pkg::*;
	logic clk, rstn, wr, rd, slow, lockOff, devWr, devRd;
	logic [7:0] addr, devAddr, devWdata, devRdata;
	logic [31:0] wdata, rdata, st;
	int fails, compares;
	clockgen_host #(.POLL_CYCLES(50)) dut_u (.clk(clk), .rstn(rstn), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .devAddr(devAddr),
		.devWdata(devWdata), .devWr(devWr), .devRd(devRd), .devRdata(devRdata));
	clockgen_dev_model dev_u (.clk(clk), .rstn(rstn), .devAddr(devAddr),
		.devWdata(devWdata), .devWr(devWr), .devRd(devRd), .devRdata(devRdata),
		.slow(slow), .lockOff(lockOff));
	always #25 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// Bounded poll of one status bit
	task automatic wait_bit(input int b, input logic v);
		int n;
		n = 0;
		rreg(HREG_STATUS, st);
		while (st[b] !== v && n < 100) begin
			rreg(HREG_STATUS, st);
			n++;
		end
	endtask
	task automatic go(input logic [2:0] m, input logic [2:0] em, input logic [1:0] ec);
		wreg(HREG_CMD, 32'(m) | 32'h0000_0008);
		wait_bit(0, 1'b0);
		chk(32'(st[6:4]), 32'(em));
		if (ec != 2'h0) chk(32'(st[3:1]), 32'({ec, 1'b1}));
		else chk(32'(st[1]), 32'h0000_0000);
	endtask
	function automatic logic [31:0] cfgw(input logic [1:0] od, input logic [2:0] rv,
		input logic ext);
		cfgw = 32'(od) | (32'(rv) << CFG_REF_DIV_LSB) | (32'({ext, ext}) << CFG_EXT_REF_SEL);
	endfunction
	task automatic end_of_test;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		wait_bit(7, 1'b1);
		chk(32'(st[7:0] & 8'hF3), 32'h0000_0080);
		chk(32'(st[16]), 32'h0000_0001);
		chk(32'(st[14]), 32'h0000_0001);
		chk(32'({dev_u.c2[7:6], dev_u.c1[5:3]}), 32'h0000_0008);
		chk(32'({dev_u.outDiv, dev_u.busDiv}), 32'h0000_0204);
		rreg(HREG_CFG, st);
		chk(st, 32'h0000_0001);
		rreg(8'h14, st);
		chk(st, 32'h0000_0000);
		$display("test reset done");
	endtask
	task automatic t_early;
		for (int m = 4; m < 8; m++) go(3'(m), 3'h0, ERR_ILLEGAL);
		wreg(HREG_CFG, cfgw(2'h0, 3'h0, 1'b0));
		go(3'h3, 3'h0, ERR_REFUSED);
		wreg(HREG_CFG, 32'(RST_CFG));
		wreg(HREG_TRIM, 32'h0000_01A5);
		wreg(HREG_CMD, 32'h0000_0010);
		wait_bit(0, 1'b0);
		chk(32'({dev_u.fine, dev_u.trm}), 32'h0000_01A5);
		chk(32'(st[17]), 32'h0000_0001);
		$display("test early done");
	endtask
	task automatic t_external;
		logic [5:0] tbl [5];
		tbl = '{6'h14, 6'h2F, 6'h02, 6'h05, 6'h21};
		wreg(HREG_EXTFREQ, 32'h0000_8000);
		wreg(HREG_CFG, cfgw(2'h1, 3'h0, 1'b1));
		slow <= 1'b1;
		go(3'h2, 3'h2, 2'h0);
		slow <= 1'b0;
		chk(32'({dev_u.c1[7:6], dev_u.c1[2], dev_u.oscRdy}), 32'h0000_0009);
		chk(32'(st[14:10]), 32'h0000_0012);
		chk(32'(st[16]), 32'h0000_0000);
		for (int i = 0; i < 5; i++) begin
			wreg(HREG_CFG, cfgw(tbl[i][5:4], tbl[i][3:1], 1'b1));
			rreg(HREG_STATUS, st);
			chk(32'(st[16]), 32'(tbl[i][0]));
		end
		wreg(HREG_CFG, cfgw(2'h1, 3'h0, 1'b1));
		go(3'h5, 3'h2, ERR_REFUSED);
		wreg(HREG_EXTFREQ, 32'h0001_0000);
		go(3'h1, 3'h2, ERR_REFUSED);
		wreg(HREG_EXTFREQ, 32'h0000_8000);
		go(3'h1, 3'h1, 2'h0);
		chk(32'({dev_u.c1[7:6], dev_u.c1[2]}), 32'h0000_0000);
		go(3'h2, 3'h2, 2'h0);
		go(3'h3, 3'h3, 2'h0);
		chk(32'({dev_u.c1[7:6], st[11:10]}), 32'h0000_0005);
		go(3'h6, 3'h6, 2'h0);
		chk(32'(dev_u.c2[C2_LOW_POWER]), 32'h0000_0001);
		go(3'h3, 3'h3, 2'h0);
		$display("test external done");
	endtask
	task automatic t_lock_pll;
		lockOff <= 1'b1;
		go(3'h0, 3'h3, ERR_TIMEOUT);
		lockOff <= 1'b0;
		go(3'h0, 3'h0, 2'h0);
		wreg(HREG_EXTFREQ, 32'h003D_0900);
		wreg(HREG_CFG, cfgw(2'h1, 3'h7, 1'b1));
		go(3'h2, 3'h2, 2'h0);
		wreg(HREG_CFG, cfgw(2'h0, 3'h1, 1'b1) | 32'h0000_2000);
		go(3'h5, 3'h5, 2'h0);
		chk(32'({dev_u.c3[C3_LOOP_TYPE_SEL], st[13]}), 32'h0000_0003);
		chk(32'(dev_u.c1[C1_INT_REF_CLK_EN]), 32'h0000_0001);
		go(3'h4, 3'h4, 2'h0);
		chk(32'({dev_u.outDiv, dev_u.busDiv}), 32'h0000_0102);
		rreg(HREG_CMD, st);
		chk(st, 32'h0000_0004);
		go(3'h5, 3'h5, 2'h0);
		go(3'h7, 3'h7, 2'h0);
		chk(32'(dev_u.c2[C2_LOW_POWER]), 32'h0000_0001);
		$display("test lock and pll done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		rstn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		slow = 1'b0;
		lockOff = 1'b0;
		fails = 0;
		compares = 0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_early();
		t_external();
		t_lock_pll();
		end_of_test();
	end
	// Whole run needs several hundred cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		end_of_test();
	end
endmodule // multi_mode_clock_generator_test
